// *** verilog/ext_bus_pkg.sv ***
// Shared constants, carriers and state codes of the external bus sequencer.
// Assumes one clock domain and configuration bits that are steady during an access.
package ext_bus_pkg;

   // ***************************************************************
   // Widths and field positions
   // ***************************************************************
   localparam int ADDR_W   = 20;
   localparam int DATA_W   = 16;
   localparam int AREAS    = 4;
   localparam int AREA_MSB = 19;
   localparam int AREA_LSB = 18;
   localparam int MUX_LSBS = 8;

   // ***************************************************************
   // Mode and field encodings
   // ***************************************************************
   localparam logic [1:0] MODE_SINGLE_CHIP    = 2'h0;
   localparam logic [1:0] MODE_MEM_EXPANSION  = 2'h1;
   localparam logic [1:0] MODE_MICROPROCESSOR = 2'h3;
   localparam logic [1:0] MUX_NONE            = 2'h0;
   localparam logic [1:0] MUX_AREA2           = 2'h1;
   localparam logic [1:0] MUX_AREA1           = 2'h2;
   localparam logic [1:0] MUX_ALL             = 2'h3;

   // ***************************************************************
   // Bus cycle lengths in bus-clock periods
   // ***************************************************************
   localparam logic [1:0] PERIODS_SEP_NOWAIT = 2'h1;
   localparam logic [1:0] PERIODS_SEP_WAIT   = 2'h2;
   localparam logic [1:0] PERIODS_MUX_NOWAIT = 2'h2;
   localparam logic [1:0] PERIODS_MUX_WAIT   = 2'h3;
   localparam logic [1:0] PERIOD_FIRST       = 2'h1;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [ADDR_W-1:0] RESET_ADDR = 20'h00000;
   localparam logic [DATA_W-1:0] RESET_DATA = 16'h0000;
   localparam logic [AREAS-1:0]  ALL_HIGH4  = 4'hf;

   // Read and write strobes, all active low.
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic low_byte_write_n;
      logic high_byte_write_n;
      logic upper_byte_enable_n;
   } strobe_s;

   localparam strobe_s STROBES_IDLE = 5'h1f;

   // Configuration bits written by software elsewhere in the chip.
   typedef struct packed {
      logic [1:0]       mode;
      logic             global_wait_bit;
      logic [AREAS-1:0] per_area_wait_bits;
      logic [1:0]       mux_select;
      logic [AREAS-1:0] select_enable;
      logic             rw_mode;
   } bus_cfg_s;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_ACCESS  = 5'h02,
      ST_FLOAT   = 5'h04,
      ST_GRANTED = 5'h08,
      ST_RESTORE = 5'h10
   } bus_state_e;

endpackage

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level; no bus coherence is promised.
module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_in,     // System clock.
   input  wire logic             resetn_in,  // Asynchronous reset, active low.
   input  wire logic [WIDTH-1:0] async_in,   // Raw pin levels.
   output logic      [WIDTH-1:0] sync_out    // Levels safe for logic.
);

   logic [WIDTH-1:0] stage1;

   // ***************************************************************
   // Synchroniser
   // ***************************************************************
   // Reset loads the idle pin levels, so no false request follows reset.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stage1   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// *** verilog/ext_bus_wait_ready_hold.sv ***
// External bus sequencer: wait insertion, ready stretching and bus release.
// Assumes a bus clock of half the system clock, generated here and driven out.
//
// Behaviour
// - Software wait on a separate-bus area makes the cycle two bus-clock periods.
// - Software wait on a multiplexed-bus area makes the cycle three bus-clock periods.
// - Global wait bit set puts a software wait on every area.
// - Global wait bit clear: wait only for areas whose own wait bit is set.
// - Ready input counts only on cycles that carry a software wait.
// - Ready low at a cycle's last bus-clock fall freezes all bus signals but the bus clock one more period.
// - Freezing goes on while ready is low; resumes at fall sampling it high.
// - Bus release works only in expansion and microprocessor modes.
// - When free after a request, float address, data, strobes and area selects at a bus-clock fall.
// - Drive the grant acknowledge low at the next bus-clock rise.
// - After the request goes high, raise grant at the next bus-clock rise.
// - After grant goes high, restore bus outputs at the next bus-clock fall.
// - Never release mid-cycle; a request waits for the cycle to finish.
// - While released, the latch strobe carries a clock in phase with the bus clock.
// - While released, address, data, strobes and area selects all float.
// - The mux select field picks multiplexed areas; all others use separate bus.
// - An area select output is driven only when software enables it.
module ext_bus_wait_ready_hold
   import ext_bus_pkg::*;
(
   input  wire logic                          clk_in,              // System clock.
   input  wire logic                          resetn_in,           // Async reset, low.
   input  wire ext_bus_pkg::bus_cfg_s         cfg_in,              // Configuration bits.
   input  wire logic                          req_in,              // Access request level.
   input  wire logic                          write_in,            // High for a write.
   input  wire logic [1:0]                    byte_en_in,          // Byte enables, high.
   input  wire logic [ext_bus_pkg::ADDR_W-1:0] addr_in,            // Access address.
   input  wire logic [ext_bus_pkg::DATA_W-1:0] wdata_in,           // Write data.
   output logic                               done_out,            // Access done pulse.
   output logic      [ext_bus_pkg::DATA_W-1:0] rdata_out,          // Read data.
   output logic                               bclk_out,            // Bus clock.
   output logic                               ale_out,             // Address latch strobe.
   output logic      [ext_bus_pkg::ADDR_W-1:0] addr_out,           // Address lines.
   output logic                               addr_oe_n_out,       // Address enable, low.
   output logic      [ext_bus_pkg::DATA_W-1:0] data_out,           // Data lines out.
   output logic                               data_oe_n_out,       // Data enable, low.
   input  wire logic [ext_bus_pkg::DATA_W-1:0] data_in,            // Data lines in.
   output ext_bus_pkg::strobe_s               strobes_out,         // Strobes, low.
   output logic                               strobe_oe_n_out,     // Strobe enable, low.
   output logic      [ext_bus_pkg::AREAS-1:0] area_select_n_out,   // Area selects, low.
   output logic      [ext_bus_pkg::AREAS-1:0] select_oe_n_out,     // Select enables, low.
   input  wire logic                          ready_n_in,          // Ready stretch, low.
   input  wire logic                          hold_n_in,           // Bus request, low.
   output logic                               bus_grant_ack_n_out  // Grant acknowledge, low.
);
   import ext_bus_pkg::*;

   // ***************************************************************
   // Helper functions
   // ***************************************************************
   // The whole-space setting is not allowed in microprocessor mode.
   function automatic logic uses_mux(input logic [1:0] area, input bus_cfg_s c);
      unique case (c.mux_select)
         MUX_NONE:  uses_mux = 1'b0;
         MUX_AREA2: uses_mux = (area == 2'h2);
         MUX_AREA1: uses_mux = (area == 2'h1);
         MUX_ALL:   uses_mux = (c.mode != MODE_MICROPROCESSOR);
      endcase
   endfunction

   function automatic strobe_s strobes_for(input logic wr, input logic [1:0] be,
                                           input logic rw_mode);
      strobe_s s;
      s.rd_n                = wr;
      s.wr_n                = !wr || rw_mode;
      s.upper_byte_enable_n = ~be[1] || (wr && rw_mode);
      s.low_byte_write_n    = !wr || !rw_mode || ~be[0];
      s.high_byte_write_n   = !wr || !rw_mode || ~be[1];
      strobes_for = s;
   endfunction

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic              ready_n_s;
   logic              hold_n_s;
   logic [DATA_W-1:0] data_s;

   pin_sync #(.WIDTH(DATA_W + 2), .RESET_VAL({RESET_DATA, 2'h3})) i_pin_sync (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .async_in  ({data_in, ready_n_in, hold_n_in}),
      .sync_out  ({data_s, ready_n_s, hold_n_s})
   );

   // ***************************************************************
   // Sequencer state
   // ***************************************************************
   bus_state_e        state, next_state;
   logic [1:0]        count, next_count, total, next_total, be, next_be, new_area;
   logic              stretch, next_stretch, is_mux, next_is_mux, waited, next_waited;
   logic              wr, next_wr, next_done, next_bclk, next_ale, next_addr_oe_n;
   logic [DATA_W-1:0] wdata, next_wdata, next_data, next_rdata;
   logic              next_data_oe_n, next_strobe_oe_n, next_bus_grant_ack_n_n;
   logic [ADDR_W-1:0] next_addr;
   strobe_s           next_strobes;
   logic [AREAS-1:0]  next_sel_n, next_sel_oe_n;
   logic              ext_mode, hold_req, rise, fall, start, do_wait, do_mux;

   // Next values; a bus-clock rise happens on the edge where bclk is low now.
   always_comb begin
      ext_mode = (cfg_in.mode == MODE_MEM_EXPANSION) ||
                 (cfg_in.mode == MODE_MICROPROCESSOR);
      hold_req = ext_mode && !hold_n_s;
      rise     = !bclk_out;
      fall     = bclk_out;
      new_area = addr_in[AREA_MSB:AREA_LSB];
      do_mux   = uses_mux(new_area, cfg_in);
      do_wait  = cfg_in.global_wait_bit || cfg_in.per_area_wait_bits[new_area];
      start    = 1'b0;
      next_state       = state;
      next_count       = count;
      next_total       = total;
      next_stretch     = stretch;
      next_is_mux      = is_mux;
      next_waited      = waited;
      next_wr          = wr;
      next_be          = be;
      next_wdata       = wdata;
      next_done        = 1'b0;
      next_bclk        = ~bclk_out;
      next_ale         = ale_out;
      next_addr        = addr_out;
      next_addr_oe_n   = addr_oe_n_out;
      next_data        = data_out;
      next_data_oe_n   = data_oe_n_out;
      next_strobes     = strobes_out;
      next_strobe_oe_n = strobe_oe_n_out;
      next_sel_n       = area_select_n_out;
      next_sel_oe_n    = select_oe_n_out;
      next_rdata       = rdata_out;
      next_bus_grant_ack_n_n      = bus_grant_ack_n_out;
      unique case (state)
         ST_IDLE: begin
            // Idle drive follows the mode; the address keeps its last value.
            next_addr_oe_n   = !ext_mode;
            next_strobe_oe_n = !ext_mode;
            next_sel_oe_n    = ext_mode ? ~cfg_in.select_enable : ALL_HIGH4;
            next_data_oe_n   = 1'b1;
            next_ale         = 1'b0;
            if (fall && hold_req) begin
               next_state       = ST_FLOAT;
               next_addr_oe_n   = 1'b1;
               next_data_oe_n   = 1'b1;
               next_strobe_oe_n = 1'b1;
               next_sel_oe_n    = ALL_HIGH4;
               next_ale         = next_bclk;
            end else if (rise && req_in && ext_mode) begin
               start = 1'b1;
            end
         end
         ST_ACCESS: begin
            if (fall) begin
               next_ale = 1'b0;
               // Ready is looked at only on the last period of a waited cycle.
               if (waited && count == total) begin
                  next_stretch = !ready_n_s;
               end
            end else if (stretch) begin
               next_stretch = 1'b0;
            end else if (count == total) begin
               // The cycle ends here; a pending request is served only now.
               next_state   = ST_IDLE;
               next_done    = 1'b1;
               next_rdata   = data_s;
               next_strobes = STROBES_IDLE;
               next_sel_n   = ALL_HIGH4;
               next_data_oe_n = 1'b1;
               if (req_in && !hold_req) begin
                  start = 1'b1;
               end
            end else begin
               next_count = count + 2'h1;
               if (is_mux && count == PERIOD_FIRST) begin
                  // Low lines turn from address to data after the latch strobe.
                  next_data      = wdata;
                  next_data_oe_n = !wr;
                  next_strobes   = strobes_for(wr, be, cfg_in.rw_mode);
               end
            end
         end
         ST_FLOAT: begin
            next_ale = next_bclk;
            if (rise) begin
               next_state  = ST_GRANTED;
               next_bus_grant_ack_n_n = 1'b0;
            end
         end
         ST_GRANTED: begin
            next_ale = next_bclk;
            if (rise && !hold_req) begin
               next_state  = ST_RESTORE;
               next_bus_grant_ack_n_n = 1'b1;
            end
         end
         ST_RESTORE: begin
            next_ale = next_bclk;
            if (fall) begin
               next_state       = ST_IDLE;
               next_ale         = 1'b0;
               next_addr_oe_n   = !ext_mode;
               next_strobe_oe_n = !ext_mode;
               next_sel_oe_n    = ext_mode ? ~cfg_in.select_enable : ALL_HIGH4;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (start) begin
         next_state   = ST_ACCESS;
         next_count   = PERIOD_FIRST;
         next_stretch = 1'b0;
         next_is_mux  = do_mux;
         next_waited  = do_wait;
         next_total   = do_mux ? (do_wait ? PERIODS_MUX_WAIT : PERIODS_MUX_NOWAIT)
                               : (do_wait ? PERIODS_SEP_WAIT : PERIODS_SEP_NOWAIT);
         next_wr      = write_in;
         next_be      = byte_en_in;
         next_wdata   = wdata_in;
         next_addr    = addr_in;
         next_sel_n   = ALL_HIGH4;
         next_sel_n[new_area] = 1'b0;
         next_sel_oe_n = ~cfg_in.select_enable;
         next_addr_oe_n   = 1'b0;
         next_strobe_oe_n = 1'b0;
         if (do_mux) begin
            next_ale       = 1'b1;
            next_data      = {wdata_in[DATA_W-1:MUX_LSBS], addr_in[MUX_LSBS-1:0]};
            next_data_oe_n = 1'b0;
            next_strobes   = STROBES_IDLE;
         end else begin
            next_ale       = 1'b0;
            next_data      = wdata_in;
            next_data_oe_n = !write_in;
            next_strobes   = strobes_for(write_in, byte_en_in, cfg_in.rw_mode);
         end
      end
   end

   // Registers only; every output leaves from here.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state               <= ST_IDLE;
         count               <= PERIOD_FIRST;
         total               <= PERIODS_SEP_NOWAIT;
         stretch             <= 1'b0;
         is_mux              <= 1'b0;
         waited              <= 1'b0;
         wr                  <= 1'b0;
         be                  <= 2'h0;
         wdata               <= RESET_DATA;
         done_out            <= 1'b0;
         rdata_out           <= RESET_DATA;
         bclk_out            <= 1'b0;
         ale_out             <= 1'b0;
         addr_out            <= RESET_ADDR;
         addr_oe_n_out       <= 1'b1;
         data_out            <= RESET_DATA;
         data_oe_n_out       <= 1'b1;
         strobes_out         <= STROBES_IDLE;
         strobe_oe_n_out     <= 1'b1;
         area_select_n_out   <= ALL_HIGH4;
         select_oe_n_out     <= ALL_HIGH4;
         bus_grant_ack_n_out <= 1'b1;
      end else begin
         state               <= next_state;
         count               <= next_count;
         total               <= next_total;
         stretch             <= next_stretch;
         is_mux              <= next_is_mux;
         waited              <= next_waited;
         wr                  <= next_wr;
         be                  <= next_be;
         wdata               <= next_wdata;
         done_out            <= next_done;
         rdata_out           <= next_rdata;
         bclk_out            <= next_bclk;
         ale_out             <= next_ale;
         addr_out            <= next_addr;
         addr_oe_n_out       <= next_addr_oe_n;
         data_out            <= next_data;
         data_oe_n_out       <= next_data_oe_n;
         strobes_out         <= next_strobes;
         strobe_oe_n_out     <= next_strobe_oe_n;
         area_select_n_out   <= next_sel_n;
         select_oe_n_out     <= next_sel_oe_n;
         bus_grant_ack_n_out <= next_bus_grant_ack_n_n;
      end
   end

endmodule

// *** tb/ext_bus_partner.sv ***
// Far-side model: a memory that answers reads, a ready source and a bus master.
// Assumes strobes and selects reach it through pull-ups when floated.
module ext_bus_partner
   import ext_bus_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr_in,     // Address.
   input  wire logic              clk_in,      // Clock.
   input  wire logic              resetn_in,   // Reset.
   input  wire strobe_s           strobes_in,  // Strobes.
   input  wire logic [AREAS-1:0]  select_n_in, // Selects.
   input  wire logic [7:0]        stall_in,    // Ready low clocks.
   input  wire logic              want_bus_in, // Master needs bus.
   output logic      [DATA_W-1:0] data_out,    // Read data.
   output logic                   ready_n_out, // Ready, low.
   output logic                   hold_n_out   // Request, low.
);
   logic [DATA_W-1:0] last;
   logic [7:0]        scnt;
   logic              sel_on;

   // ***********************
   // Memory and ready source
   // ***********************
   // Outside a read the lines show a changing pattern, never a stale value.
   assign sel_on = select_n_in != ALL_HIGH4;
   assign data_out = strobes_in.rd_n ? ~last : (addr_in[15:0] ^ 16'h5a3c);
   assign ready_n_out = !(sel_on && scnt < stall_in);
   // The master only asks; it drives nothing, so grant rules stay trivially kept.
   assign hold_n_out = !want_bus_in;

   // Clocks since the select fell, for the ready stretch.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         last <= 16'h0000;
         scnt <= 8'h00;
      end else begin
         last <= data_out;
         scnt <= sel_on ? scnt + 8'h01 : 8'h00;
      end
   end
endmodule

// *** tb/ext_bus_checker.sv ***
// Port timing checker of the external bus sequencer.
// Assumes configuration bits stay steady while a bus cycle runs.
module ext_bus_checker
   import ext_bus_pkg::*;
(
   input wire logic                          clk_in,              // Clock.
   input wire logic                          resetn_in,           // Reset.
   input wire ext_bus_pkg::bus_cfg_s         cfg_in,              // Config.
   input wire logic                          hold_n_in,           // Request.
   input wire logic                          done_out,            // Done.
   input wire logic                          bclk_out,            // Bus clock.
   input wire logic                          ale_out,             // Latch.
   input wire logic [ext_bus_pkg::ADDR_W-1:0] addr_out,           // Address.
   input wire logic                          addr_oe_n_out,       // Addr oe.
   input wire logic                          data_oe_n_out,       // Data oe.
   input wire ext_bus_pkg::strobe_s          strobes_out,         // Strobes.
   input wire logic                          strobe_oe_n_out,     // Strobe oe.
   input wire logic [ext_bus_pkg::AREAS-1:0] area_select_n_out,   // Selects.
   input wire logic [ext_bus_pkg::AREAS-1:0] select_oe_n_out,     // Select oe.
   input wire logic                          bus_grant_ack_n_out  // Grant.
);
   logic [7:0] cnt, next_cnt, span;
   logic [1:0] area;
   logic       waited, muxed, sel_on;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   // *****************
   // Cycle length model
   // *****************
   // Clocks of the running cycle; restarts at done so back-to-back cycles count apart.
   always_comb begin
      sel_on = area_select_n_out != ALL_HIGH4;
      area = addr_out[AREA_MSB:AREA_LSB];
      waited = cfg_in.global_wait_bit | cfg_in.per_area_wait_bits[area];
      case (cfg_in.mux_select)
         MUX_AREA2: muxed = area == 2'h2;
         MUX_AREA1: muxed = area == 2'h1;
         MUX_ALL:   muxed = cfg_in.mode != MODE_MICROPROCESSOR;
         default:   muxed = 1'b0;
      endcase
      span = {5'h00, muxed ? (waited ? PERIODS_MUX_WAIT : PERIODS_MUX_NOWAIT)
                           : (waited ? PERIODS_SEP_WAIT : PERIODS_SEP_NOWAIT), 1'b0};
      next_cnt = 8'h00;
      if (sel_on) next_cnt = done_out ? 8'h01 : cnt + 8'h01;
   end

   // Registered count.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) cnt <= 8'h00;
      else cnt <= next_cnt;
   end

   AST_CYCLE_LEN: assert property (done_out |-> cnt >= span && !cnt[0])
      else $error("bus cycle length wrong");
   AST_READY_IGNORED: assert property (done_out && !waited |-> cnt == span)
      else $error("unwaited cycle stretched");
   AST_FROZEN: assert property (sel_on && $past(sel_on) && !done_out |-> $stable(addr_out))
      else $error("address moved in a cycle");
   AST_FLOAT: assert property (!bus_grant_ack_n_out |-> addr_oe_n_out && data_oe_n_out
      && strobe_oe_n_out && select_oe_n_out == ALL_HIGH4) else $error("bus driven in grant");
   AST_ALE_CLOCK: assert property (!bus_grant_ack_n_out |-> ale_out == bclk_out)
      else $error("latch strobe not bus clock");
   AST_GRANT_EDGE: assert property ($fell(bus_grant_ack_n_out) |-> bclk_out &&
      $past(addr_oe_n_out) && $past(strobe_oe_n_out)) else $error("grant before float");
   AST_HOLD_MODE: assert property ($fell(bus_grant_ack_n_out) |-> cfg_in.mode ==
      MODE_MEM_EXPANSION || cfg_in.mode == MODE_MICROPROCESSOR) else $error("grant in chip");
   AST_RELEASE: assert property ($rose(bus_grant_ack_n_out) |-> $past(hold_n_in) && bclk_out)
      else $error("grant rose wrongly");
   AST_RESTORE: assert property ($rose(bus_grant_ack_n_out) |-> addr_oe_n_out ##1
      !addr_oe_n_out) else $error("bus not restored");
   AST_WHOLE: assert property ($rose(strobe_oe_n_out) |-> $past(strobes_out) == STROBES_IDLE)
      else $error("released mid cycle");
   AST_SEL_EN: assert property (((~select_oe_n_out) & ~$past(cfg_in.select_enable)) == 4'h0)
      else $error("disabled select driven");
endmodule

bind ext_bus_wait_ready_hold ext_bus_checker i_ext_bus_checker (.clk_in, .resetn_in, .cfg_in,
   .hold_n_in, .done_out, .bclk_out, .ale_out, .addr_out, .addr_oe_n_out, .data_oe_n_out,
   .strobes_out, .strobe_oe_n_out, .area_select_n_out, .select_oe_n_out, .bus_grant_ack_n_out);

// *** tb/tb_ext_bus_wait_ready_hold.sv ***
// Self-checking bench of the external bus sequencer.
// Assumes the partner model answers reads, stretches ready and requests the bus.
module tb_ext_bus_wait_ready_hold;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_bus_pkg::*;
   logic clk_in = 1'b0, resetn_in = 1'b0, req = 1'b0, wr = 1'b0, want = 1'b0;
   logic done, bclk, ale, aoe, doe, soe, grant, rdy, hold, gl, chg;
   logic [1:0] be = 2'h3;
   logic [19:0] addr = 20'h00000, aout;
   logic [15:0] wd = 16'hbeef, rd, dout, pdata, dbus;
   logic [3:0] sel, seloe;
   logic [7:0] stall = 8'h00;
   logic [11:0] tbl [8] = '{12'h001, 12'h886, 12'h90a, 12'h10d, 12'h01a, 12'h8a7,
                            12'hc2a, 12'h03e};
   bus_cfg_s cfg = '0;
   strobe_s stb, lo;
   int bad_count = 0, num_checks = 0, len, i, n;

   // Floated strobes, selects and data fall to the pull-ups or the far side.
   assign dbus = doe ? pdata : dout;
   ext_bus_wait_ready_hold i_ext_bus_wait_ready_hold (.clk_in(clk_in), .resetn_in(resetn_in),
      .cfg_in(cfg), .req_in(req), .write_in(wr), .byte_en_in(be), .addr_in(addr),
      .wdata_in(wd), .done_out(done), .rdata_out(rd), .bclk_out(bclk), .ale_out(ale),
      .addr_out(aout), .addr_oe_n_out(aoe), .data_out(dout), .data_oe_n_out(doe),
      .data_in(dbus), .strobes_out(stb), .strobe_oe_n_out(soe), .area_select_n_out(sel),
      .select_oe_n_out(seloe), .ready_n_in(rdy), .hold_n_in(hold), .bus_grant_ack_n_out(grant));
   ext_bus_partner i_ext_bus_partner (.addr_in(aout), .clk_in(clk_in), .resetn_in(resetn_in),
      .strobes_in(soe ? STROBES_IDLE : stb), .select_n_in(sel | seloe), .stall_in(stall),
      .want_bus_in(want), .data_out(pdata), .ready_n_out(rdy), .hold_n_out(hold));

   // Clock and watchdog.
   initial forever #20 clk_in = ~clk_in;
   initial begin
      #(40 * 20000);
      bad_count++;
      finish_test();
   end

   // Compares a value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access from a bus rise; len is clocks from taking to done.
   task automatic access(input logic w, input logic [19:0] a, input int hold_at);
      logic [19:0] held;
      lo = STROBES_IDLE;
      gl = 1'b0;
      chg = 1'b0;
      @(negedge clk_in);
      while (bclk !== 1'b0) @(negedge clk_in);
      wr = w;
      addr = a;
      req = 1'b1;
      @(negedge clk_in);
      req = 1'b0;
      held = aout;
      for (n = 1; n < 200 && done !== 1'b1; n++) begin
         if (n == hold_at) want = 1'b1;
         lo = lo & stb;
         gl = gl | !grant;
         chg = chg | (aout !== held);
         @(negedge clk_in);
      end
      len = n - 1;
      @(negedge clk_in); // Settings stay put until the checker has seen done.
   endtask

   // Waits a bounded time for the grant to reach a level.
   task automatic wait_grant(input logic lvl);
      for (n = 0; n < 40 && grant !== lvl; n++) @(negedge clk_in);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // *************
   // Test sequence
   // *************
   initial begin
      cfg.mode = MODE_MEM_EXPANSION;
      cfg.select_enable = ALL_HIGH4;
      repeat (4) @(negedge clk_in);
      chk({grant, done, aoe, doe, soe, seloe}, 9'h17f);
      resetn_in = 1'b1;
      for (i = 0; i < 8; i++) begin
         {cfg.global_wait_bit, cfg.per_area_wait_bits, cfg.mux_select} = tbl[i][10:4];
         access(1'b0, {tbl[i][3:2], 18'h01234}, 0);
         chk(len, {tbl[i][1:0], 1'b0});
         if (tbl[i][11]) chk(rd, 16'h1234 ^ 16'h5a3c);
      end
      cfg.rw_mode = 1'b1;
      be = 2'h1;
      access(1'b1, 20'h02000, 0);
      chk({lo.rd_n, lo.low_byte_write_n, lo.high_byte_write_n}, 3'h5);
      chk(dout, wd);
      $display("test wait_lengths done");
      {cfg.global_wait_bit, cfg.mux_select, cfg.rw_mode, stall} = {4'h8, 8'h08};
      access(1'b0, 20'h01000, 0);
      chk((len >= 10) && (len <= 14) && !len[0], 1'b1);
      chk(chg, 1'b0);
      cfg.global_wait_bit = 1'b0;
      access(1'b0, 20'h01000, 0);
      chk(len, 2);
      $display("test ready_stretch done");
      cfg.select_enable = 4'h5;
      want = 1'b1;
      wait_grant(1'b0);
      chk({grant, aoe, doe, soe, seloe}, 8'h7f);
      repeat (6) @(negedge clk_in);
      want = 1'b0;
      wait_grant(1'b1);
      repeat (2) @(negedge clk_in);
      chk({grant, aoe, seloe}, 6'h2a);
      cfg.select_enable = ALL_HIGH4;
      {cfg.global_wait_bit, cfg.mux_select} = {1'b1, MUX_AREA1};
      access(1'b0, 20'h40000, 3);
      chk(gl, 1'b0);
      wait_grant(1'b0);
      chk(grant, 1'b0);
      want = 1'b0;
      wait_grant(1'b1);
      repeat (2) @(negedge clk_in);
      $display("test bus_release done");
      cfg.mode = MODE_SINGLE_CHIP;
      want = 1'b1;
      repeat (20) @(negedge clk_in);
      chk(grant, 1'b1);
      want = 1'b0;
      $display("test single_chip done");
      finish_test();
   end
endmodule
